//--- design/par_port_params.svh
// timing and code constants for the parallel printer port
`ifndef PAR_PORT_PARAMS_SVH
`define PAR_PORT_PARAMS_SVH
`define CLK_MHZ 100
`define STROBE_MIN_NS 500
`define STROBE_MIN_CYC ((`STROBE_MIN_NS * `CLK_MHZ + 999) / 1000)
`define DATA_HOLD_NS 500
`define DATA_HOLD_CYC ((`DATA_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define ACK_PULSE_NS 12000
`define ACK_PULSE_CYC ((`ACK_PULSE_NS * `CLK_MHZ) / 1000)
`define BUF_DEPTH 16
`define CHAR_CR 8'h0D
`define CHAR_ESC 8'h1B
`define CHAR_EIGHT 8'h38
`endif

//--- design/par_port_pkg.sv
// types shared by both ends of the parallel printer port
package par_port_pkg;
    typedef logic [7:0] char_t;
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_TAKE = 2'b01,
        DEV_ACK = 2'b10,
        DEV_PRINT = 2'b11
    } dev_state_e;
    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_STROBE = 2'b01,
        HST_WAIT = 2'b10
    } host_state_e;
endpackage

//--- design/par_port_if.sv
// pin bundle between host and printer
`timescale 1ns/1ps
`default_nettype none
interface par_port_if;
    logic strobe_n;
    logic [7:0] data;
    logic char_accept_pulse;
    logic busy;
    logic paper_out_flag;
    logic selected_status_out;
    logic error_n;
    logic auto_line_advance_n;
    logic printer_init_n;
    logic select_request_in;
    modport printer (
        input strobe_n, data, auto_line_advance_n, printer_init_n,
        input select_request_in,
        output char_accept_pulse, busy, paper_out_flag,
        output selected_status_out, error_n
    );
    modport host (
        output strobe_n, data, auto_line_advance_n, printer_init_n,
        output select_request_in,
        input char_accept_pulse, busy, paper_out_flag,
        input selected_status_out, error_n
    );
endinterface
`default_nettype wire

//--- design/par_printer_end.sv
// printer end of the parallel host port
// Operation
// - host strobe low at least 0.5 us
// - eight data lines, high is one
// - host holds data 0.5 us from strobe
// - acknowledge pulse about 12 us after character
// - host sends next only after acknowledge
// - busy high when no character accepted
// - busy during entry, print, offline, error
// - paper out output high when exhausted
// - auto line feed low feeds after print
// - init low resets and clears buffer
// - error low on paper end, offline, fault
// - paper end sensed only at line feed
// - escape eight masks paper end error
// - select in low selects, reported out
// - host never ignores acknowledge and busy
`include "par_port_params.svh"
`timescale 1ns/1ps
`default_nettype none
module par_printer_end (
    input wire logic clk,
    input wire logic sys_rst,
    par_port_if.printer port,
    input wire logic paper_sensor_empty,
    input wire logic hw_fault,
    input wire logic print_done,
    output logic print_start,
    output logic line_feed,
    output logic [7:0] char_out,
    output logic char_valid
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // transfer sequencing and received character
    par_port_pkg::dev_state_e state_ff;
    par_port_pkg::char_t data_ff;
    logic strobe_d_ff;
    logic [10:0] ack_cnt_ff;
    logic [4:0] fill_ff;

    // paper end, escape mask and select status
    logic paper_end_ff;
    logic pe_mask_ff;
    logic esc_seen_ff;
    logic selected_ff;

    // pending feed and mechanism side pulses
    logic feed_pend_ff;
    logic print_start_ff;
    logic line_feed_ff;
    logic char_valid_ff;

    // decoded conditions
    logic init_act;
    logic strobe_fall;
    logic offline;
    logic err_cond;
    logic flush;

    // ----------------------------------------------------------------
    // decoded conditions
    // ----------------------------------------------------------------
    // initialise line clears all but the strobe edge detector
    assign init_act = sys_rst || !port.printer_init_n;
    // falling strobe against the previous sample
    assign strobe_fall = strobe_d_ff && !port.strobe_n;
    // deselected counts as off line
    assign offline = !selected_ff;
    // any condition that refuses a new character
    assign err_cond = offline || hw_fault || paper_end_ff;
    // print on full buffer or carriage return
    assign flush = (fill_ff == 5'(`BUF_DEPTH - 1)) ||
                   (data_ff == `CHAR_CR);

    // ----------------------------------------------------------------
    // strobe edge detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobe_d_ff <= 1'b1;
        end else begin
            strobe_d_ff <= port.strobe_n;
        end
    end

    // ----------------------------------------------------------------
    // transfer sequencing
    // ----------------------------------------------------------------
    // one step per clock, acknowledge counted down in place
    always_ff @(posedge clk) begin
        if (init_act) begin
            state_ff <= par_port_pkg::DEV_IDLE;
            ack_cnt_ff <= '0;
            data_ff <= '0;
            char_valid_ff <= 1'b0;
            print_start_ff <= 1'b0;
            fill_ff <= '0;
        end else begin
            char_valid_ff <= 1'b0;
            print_start_ff <= 1'b0;
            case (state_ff)
                par_port_pkg::DEV_IDLE: begin
                    if (strobe_fall && !err_cond) begin
                        data_ff <= port.data;
                        state_ff <= par_port_pkg::DEV_TAKE;
                    end
                end
                par_port_pkg::DEV_TAKE: begin
                    char_valid_ff <= 1'b1;
                    ack_cnt_ff <= 11'(`ACK_PULSE_CYC);
                    if (flush) begin
                        fill_ff <= '0;
                        print_start_ff <= 1'b1;
                        state_ff <= par_port_pkg::DEV_PRINT;
                    end else begin
                        fill_ff <= fill_ff + 5'h1;
                        state_ff <= par_port_pkg::DEV_ACK;
                    end
                end
                par_port_pkg::DEV_PRINT: begin
                    if (print_done) begin
                        state_ff <= par_port_pkg::DEV_ACK;
                    end
                end
                par_port_pkg::DEV_ACK: begin
                    if (ack_cnt_ff == 11'h1) begin
                        state_ff <= par_port_pkg::DEV_IDLE;
                    end
                    ack_cnt_ff <= ack_cnt_ff - 11'h1;
                end
                default: state_ff <= par_port_pkg::DEV_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // line feed and paper end handling
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (init_act) begin
            feed_pend_ff <= 1'b0;
            line_feed_ff <= 1'b0;
            paper_end_ff <= 1'b0;
        end else begin
            line_feed_ff <= 1'b0;
            // feed after the print that the mechanism reports done
            if (feed_pend_ff && print_done) begin
                feed_pend_ff <= 1'b0;
                line_feed_ff <= 1'b1;
                paper_end_ff <= paper_sensor_empty;
            end
            // new request assigned last so it wins over the clear
            if (print_start_ff && !port.auto_line_advance_n) begin
                feed_pend_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // escape and select status
    // ----------------------------------------------------------------
    // escape followed by eight sets the paper end mask
    always_ff @(posedge clk) begin
        if (init_act) begin
            esc_seen_ff <= 1'b0;
            pe_mask_ff <= 1'b0;
        end else if (char_valid_ff) begin
            esc_seen_ff <= (data_ff == `CHAR_ESC);
            if (esc_seen_ff && data_ff == `CHAR_EIGHT) begin
                pe_mask_ff <= 1'b1;
            end
        end
    end

    // select state follows select request when error free
    always_ff @(posedge clk) begin
        if (init_act) begin
            selected_ff <= 1'b0;
        end else if (!hw_fault && !paper_end_ff) begin
            selected_ff <= !port.select_request_in;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    // acknowledge stands for the whole count
    assign port.char_accept_pulse = (state_ff == par_port_pkg::DEV_ACK);
    assign port.busy = (state_ff != par_port_pkg::DEV_IDLE) || err_cond ||
                       !port.strobe_n;

    // status levels
    assign port.paper_out_flag = paper_end_ff;
    assign port.selected_status_out = selected_ff;
    assign port.error_n = !(offline || hw_fault ||
                            (paper_end_ff && !pe_mask_ff));

    // mechanism side outputs
    assign print_start = print_start_ff;
    assign line_feed = line_feed_ff;
    assign char_out = data_ff;
    assign char_valid = char_valid_ff;
endmodule
`default_nettype wire

//--- design/par_host_end.sv
// host end of the parallel printer port
`include "par_port_params.svh"
`timescale 1ns/1ps
`default_nettype none
module par_host_end (
    input wire logic clk,
    input wire logic sys_rst,
    par_port_if.host port,
    input wire logic [7:0] send_char,
    input wire logic send_valid,
    output logic send_ready,
    input wire logic auto_feed_req,
    input wire logic init_req,
    input wire logic select_req,
    output logic printer_error,
    output logic printer_paper_out,
    output logic printer_selected
);
    par_port_pkg::host_state_e state_ff;
    par_port_pkg::char_t data_ff;
    logic [5:0] cnt_ff;
    logic strobe_n_ff;
    logic ack_seen_ff;

    // ----------------------------------------------------------------
    // strobe sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= par_port_pkg::HST_IDLE;
            data_ff <= '0;
            cnt_ff <= '0;
            strobe_n_ff <= 1'b1;
            ack_seen_ff <= 1'b0;
        end else begin
            case (state_ff)
                par_port_pkg::HST_IDLE: begin
                    if (send_valid && !port.busy && port.error_n) begin
                        data_ff <= send_char;
                        strobe_n_ff <= 1'b0;
                        cnt_ff <= 6'(`STROBE_MIN_CYC);
                        state_ff <= par_port_pkg::HST_STROBE;
                    end
                end
                par_port_pkg::HST_STROBE: begin
                    // data stays fixed until acknowledge
                    if (cnt_ff == 6'h1) begin
                        strobe_n_ff <= 1'b1;
                        ack_seen_ff <= 1'b0;
                        state_ff <= par_port_pkg::HST_WAIT;
                    end
                    cnt_ff <= cnt_ff - 6'h1;
                end
                par_port_pkg::HST_WAIT: begin
                    if (port.char_accept_pulse) begin
                        ack_seen_ff <= 1'b1;
                    end
                    if (ack_seen_ff && !port.char_accept_pulse) begin
                        state_ff <= par_port_pkg::HST_IDLE;
                    end
                end
                default: state_ff <= par_port_pkg::HST_IDLE;
            endcase
        end
    end

    // pin drive and status pass-through
    assign port.strobe_n = strobe_n_ff;
    assign port.data = data_ff;
    assign port.auto_line_advance_n = !auto_feed_req;
    assign port.printer_init_n = !init_req;
    assign port.select_request_in = !select_req;
    assign send_ready = (state_ff == par_port_pkg::HST_IDLE) &&
                        !port.busy && port.error_n;
    assign printer_error = !port.error_n;
    assign printer_paper_out = port.paper_out_flag;
    assign printer_selected = port.selected_status_out;
endmodule
`default_nettype wire

//--- dv/printer_parallel_host_port_assertions.sv
// wire-level checks between host end and printer end
`timescale 1ns/1ps
`default_nettype none
`include "par_port_params.svh"
module printer_parallel_host_port_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic strobe_n,
    input wire logic [7:0] data,
    input wire logic char_accept_pulse,
    input wire logic busy,
    input wire logic paper_out_flag,
    input wire logic selected_status_out,
    input wire logic error_n,
    input wire logic printer_init_n,
    input wire logic select_request_in
);
    localparam int ACK_CYC = `ACK_PULSE_CYC;
    localparam int STB_CYC = `STROBE_MIN_CYC;
    logic [15:0] stb_len_ff;
    logic [15:0] ack_len_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // cycles spent with strobe low
    always_ff @(posedge clk) begin
        stb_len_ff <= strobe_n ? 16'h0000 : stb_len_ff + 16'h0001;
    end
    // cycles spent with acknowledge high
    always_ff @(posedge clk) begin
        ack_len_ff <= char_accept_pulse ? ack_len_ff + 16'h0001 : 16'h0000;
    end
    chk_busy_strobe: assert property (!strobe_n |-> busy)
        else $error("busy low under strobe");
    chk_ack_busy: assert property (char_accept_pulse |-> busy)
        else $error("busy low during ack");
    chk_ack_width: assert property (
        $fell(char_accept_pulse) && $past(printer_init_n) |->
        ack_len_ff == ACK_CYC)
        else $error("ack width wrong");
    // ready again once the pulse ends with no error pending
    chk_busy_release: assert property (
        $fell(char_accept_pulse) && error_n && !paper_out_flag &&
        strobe_n |-> !busy)
        else $error("busy held after ack");
    chk_error_busy: assert property (!error_n |-> busy)
        else $error("busy low in error");
    chk_offline_err: assert property (
        !selected_status_out |-> !error_n)
        else $error("no error when offline");
    chk_init_state: assert property (!printer_init_n |=>
        !selected_status_out && !char_accept_pulse && busy && !paper_out_flag)
        else $error("init did not reset");
    chk_deselect: assert property (select_request_in &&
        printer_init_n |=> !selected_status_out)
        else $error("selected while select in high");
    chk_strobe_busy: assert property (
        $fell(strobe_n) |-> !$past(busy))
        else $error("strobe while busy");
    chk_strobe_width: assert property ($rose(strobe_n) |->
        stb_len_ff >= STB_CYC)
        else $error("strobe too short");
    chk_data_hold: assert property (
        !strobe_n && stb_len_ff != 0 && stb_len_ff < STB_CYC |->
        $stable(data))
        else $error("data moved in hold");
    cov_ack: cover property ($fell(char_accept_pulse));
    cov_paper: cover property ($rose(paper_out_flag));
    cov_desel: cover property ($fell(selected_status_out));
endmodule
`default_nettype wire

//--- dv/printer_parallel_host_port_tb.sv
// bench for both ends of the printer parallel port
`timescale 1ns/1ps
`default_nettype none
`include "par_port_params.svh"
module printer_parallel_host_port_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic paper_sensor_empty = 1'b0;
    logic hw_fault = 1'b0;
    logic print_done = 1'b0;
    logic print_start, line_feed, char_valid, send_ready;
    logic [7:0] char_out;
    par_port_pkg::char_t send_char = 8'h00;
    logic send_valid = 1'b0;
    logic auto_feed_req = 1'b0;
    logic init_req = 1'b0;
    logic select_req = 1'b0;
    logic printer_error, printer_paper_out, printer_selected;
    int fails = 0;
    int checked = 0;
    int feeds = 0;
    int prints = 0;
    int cycles = 0;
    par_port_pkg::char_t exp_q[$];
    par_port_if port_if();
    par_printer_end par_printer_end_inst (.clk, .sys_rst, .port(port_if),
        .paper_sensor_empty, .hw_fault, .print_done, .print_start,
        .line_feed, .char_out, .char_valid);
    par_host_end par_host_end_inst (.clk, .sys_rst, .port(port_if),
        .send_char, .send_valid, .send_ready, .auto_feed_req, .init_req,
        .select_req, .printer_error, .printer_paper_out, .printer_selected);
    printer_parallel_host_port_assertions
        printer_parallel_host_port_assertions_inst (.clk, .sys_rst,
        .strobe_n(port_if.strobe_n), .data(port_if.data),
        .char_accept_pulse(port_if.char_accept_pulse), .busy(port_if.busy),
        .paper_out_flag(port_if.paper_out_flag),
        .selected_status_out(port_if.selected_status_out),
        .error_n(port_if.error_n), .printer_init_n(port_if.printer_init_n),
        .select_request_in(port_if.select_request_in));
    initial forever #5 clk = ~clk;
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic exp_err(input logic pe, input logic mask,
        input logic flt, input logic sel);
        return (pe && !mask) || flt || !sel;
    endfunction
    // random character steered off the control codes
    function automatic par_port_pkg::char_t pick(input logic [7:0] r);
        return (r == `CHAR_CR || r == `CHAR_ESC) ? r ^ 8'h40 : r;
    endfunction
    // offer one character and drop valid once the host takes it
    task automatic send(input par_port_pkg::char_t c);
        int n;
        n = 0;
        while (send_ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (send_ready !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t send never ready", $time);
        end
        exp_q.push_back(c);
        send_char = c;
        send_valid = 1'b1;
        @(negedge clk);
        while (send_ready === 1'b1 && n < 5100) begin
            @(negedge clk);
            n++;
        end
        if (send_ready === 1'b1) begin
            fails++;
            $display("MISMATCH %0t send never taken", $time);
        end
        send_valid = 1'b0;
    endtask
    // wait until ready again, bounded
    task automatic idle();
        int n;
        n = 0;
        while (send_ready !== 1'b1 && n < 1500) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic do_init();
        init_req = 1'b1;
        repeat (5) @(negedge clk);
        init_req = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    // mechanism answers each print after a short delay
    initial forever begin
        @(posedge clk iff print_start === 1'b1);
        prints++;
        repeat (8) @(negedge clk);
        print_done = 1'b1;
        @(negedge clk);
        print_done = 1'b0;
    end
    // feeds counted, received characters compared in order
    always @(posedge clk) begin
        if (line_feed === 1'b1) feeds++;
        if (char_valid === 1'b1) begin
            chk(exp_q.size() > 0, "char unexpected");
            if (exp_q.size() > 0) begin
                chk(char_out === exp_q[0], "char");
                void'(exp_q.pop_front());
            end
        end
    end
    // cycle ceiling against a hang
    initial begin
        while (cycles < 90000) begin
            @(posedge clk);
            cycles++;
        end
        fails++;
        $display("MISMATCH %0t timeout", $time);
        end_of_test();
    end
    initial begin
        void'($urandom(32'h4163));
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        select_req = 1'b1;
        repeat (4) @(negedge clk);
        chk(printer_selected === 1'b1, "not selected");
        chk(send_ready === 1'b1, "not ready");
        send(8'hFF);
        send(8'h00);
        for (int i = 0; i < `BUF_DEPTH - 2; i++) send(pick(8'($urandom)));
        idle();
        chk(prints == 1 && feeds == 0, "full buffer");
        auto_feed_req = 1'b1;
        send(`CHAR_CR);
        idle();
        chk(prints == 2 && feeds == 1, "cr feed");
        paper_sensor_empty = 1'b1;
        repeat (4) @(negedge clk);
        chk(printer_paper_out === 1'b0, "pe before feed");
        send(`CHAR_CR);
        idle();
        chk(printer_paper_out === 1'b1, "paper out");
        chk(printer_error === exp_err(1, 0, 0, 1), "pe error");
        chk(send_ready === 1'b0, "ready in error");
        do_init();
        chk(printer_paper_out === 1'b0, "init pe");
        chk(printer_error === 1'b0, "init error");
        send(`CHAR_ESC);
        send(`CHAR_EIGHT);
        send(`CHAR_CR);
        idle();
        chk(printer_error === exp_err(1, 1, 0, 1), "mask");
        do_init();
        paper_sensor_empty = 1'b0;
        hw_fault = 1'b1;
        repeat (3) @(negedge clk);
        chk(printer_error === exp_err(0, 0, 1, 1), "fault");
        chk(send_ready === 1'b0, "ready in fault");
        hw_fault = 1'b0;
        select_req = 1'b0;
        repeat (3) @(negedge clk);
        chk(printer_error === exp_err(0, 0, 0, 0), "offline");
        select_req = 1'b1;
        repeat (3) @(negedge clk);
        chk(printer_selected === 1'b1, "reselect");
        send(pick(8'($urandom)));
        idle();
        chk(exp_q.size() == 0, "chars lost");
        end_of_test();
    end
endmodule
`default_nettype wire
